// ===== common/vcl_pkg.sv
// shared constants and types for the video control lock registers
package vcl_pkg;
    // ---------------------------------------------
    // host ports and indices
    // ---------------------------------------------
    localparam logic [15:0] PORT_GFX_IDX  = 16'h03CE;
    localparam logic [15:0] PORT_GFX_DATA = 16'h03CF;
    localparam logic [15:0] PORT_MISC_WR  = 16'h03C2;
    localparam logic [15:0] PORT_CRT_MONO = 16'h03B5;
    localparam logic [15:0] PORT_CRT_COLR = 16'h03D5;
    localparam logic [7:0]  IDX_VIDEO_SELECT = 8'h0C;
    localparam logic [7:0]  IDX_CRT_LOCK     = 8'h0D;
    localparam logic [7:0]  IDX_VIDEO_OUT    = 8'h0E;
    localparam logic [7:0]  IDX_UNLOCK       = 8'h0F;
    localparam logic [3:0]  UNLOCK_KEY       = 4'h5;
    localparam logic [7:0]  RST_REG          = 8'h00;
    // ---------------------------------------------
    // crt register indices and lock masks
    // ---------------------------------------------
    localparam logic [7:0] CRT_R05 = 8'h05;
    localparam logic [7:0] CRT_R06 = 8'h06;
    localparam logic [7:0] CRT_R07 = 8'h07;
    localparam logic [7:0] CRT_R09 = 8'h09;
    localparam logic [7:0] CRT_R10 = 8'h10;
    localparam logic [7:0] CRT_R11 = 8'h11;
    localparam logic [7:0] CRT_R15 = 8'h15;
    localparam logic [7:0] CRT_R16 = 8'h16;
    localparam logic [7:0] CRT_R17 = 8'h17;
    localparam logic [7:0] M07_GRP1 = 8'h42;
    localparam logic [7:0] M07_GRP2 = 8'hAD;
    localparam logic [7:0] M09_GRP3 = 8'h20;
    localparam logic [7:0] M11_GRP3 = 8'h0F;
    localparam logic [7:0] M17_GRP4 = 8'h04;
    localparam logic [7:0] M_MISC_POL = 8'hC0;
    localparam logic [7:0] M_ALL    = 8'hFF;
    // ---------------------------------------------
    // field positions
    // ---------------------------------------------
    localparam int VS_FORCE = 0;
    localparam int VS_CLK3  = 1;
    localparam int VS_ULINE = 2;
    localparam int VS_CCLK  = 3;
    localparam int VS_MAP   = 5;
    localparam int VS_LEGACY = 6;
    localparam int CL_VLOCK = 0;
    localparam int CL_PREV  = 1;
    localparam int CL_DBL   = 2;
    localparam int CL_B8    = 3;
    localparam int CL_B9    = 4;
    localparam int CL_HLOCK = 5;
    localparam int CL_HPOL  = 6;
    localparam int CL_VPOL  = 7;
    localparam int VO_SHIFT = 0;
    localparam int VO_EGA   = 1;
    localparam int VO_CGA   = 3;
    localparam int VO_MTRI  = 4;
    localparam int VO_VTRI  = 5;
    localparam int VO_PCLK  = 6;
    localparam int VO_BLANKING_OUTPUT  = 7;
    localparam logic [3:0] PAN_ZERO = 4'h9;
    localparam logic [3:0] PAN_ONE  = 4'h8;
    // ---------------------------------------------
    // types
    // ---------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  data;
    } vcl_req_t;
    typedef struct packed {
        logic       pass;
        logic [7:0] mask;
        logic [7:0] data;
    } vcl_wr_t;
    typedef enum logic [3:0] {
        CW_STD = 4'b0001,
        CW_7   = 4'b0010,
        CW_9   = 4'b0100,
        CW_10  = 4'b1000
    } vcl_cw_t;
endpackage

// ===== hdl/vcl_regs.sv
// video select, crt lock and video output control registers
//
// Function
// [R1] compat bit selects legacy character timing
// [R2] glyph plane 3 per map, underline, attr4
// [R3] two-bit field sets text cell width
// [R4] cell width ignored in graphics modes
// [R5] ten-dot cells remap pel panning values
// [R6] underline odd attributes, background intensity zero
// [R7] strap routes clock bit or freezes mux
// [R8] force bit runs crt on full clock
// [R9] horizontal group locked by lock or protect
// [R10] display-end high bits lock needs prevention clear
// [R11] vertical group locked by lock or protect
// [R12] vertical extras locked only by vertical lock
// [R13] register 17 bit 2 locked by horizontal
// [R14] polarity bits of misc output frozen
// [R15] extension bits give address bits 17,16
// [R16] scan doubling doubles cursor and row values
// [R17] blank pin may carry display enable
// [R18] pixel clock source select
// [R19] video tri-state floats pixel, syncs, blank
// [R20] memory tri-state floats address and strobes
// [R21] override forces legacy video enable in 80x25 mode only
// [R22] legacy compat disables extension reads
// [R23] shift register control for 256 colours
// [R24] writes need unlock key in unlock register
// [R25] locked crt field keeps stored value
// [R26] the three control registers clear at reset; output enables reset to 1
`timescale 1ns/1ps
`default_nettype none
module vcl_regs (
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire vcl_pkg::vcl_req_t bus_req,
    output logic                rd_ack_r,
    output logic [7:0]          rd_data_r,
    input  wire logic [7:0]     crt_index,
    input  wire logic           crt_protect,
    output vcl_pkg::vcl_wr_t    fwd_wr_r,
    input  wire logic           external_clock_strap,
    input  wire logic           video_clock_input,
    input  wire logic           dot_clock_level,
    input  wire logic           graphics_mode,
    input  wire logic           page_mode_addressing,
    input  wire logic           attribute_bit_four,
    input  wire logic           sequencer_clocking_mode,
    input  wire logic [3:0]     pan_value,
    input  wire logic           blank_in,
    input  wire logic           disp_en_a,
    input  wire logic           disp_en_b,
    input  wire logic           enable_timing_variant,
    input  wire logic           legacy_80x25,
    input  wire logic           cga_video_en,
    output logic                legacy_timing_r,
    output logic                glyph_plane3_r,
    output vcl_pkg::vcl_cw_t    cell_width_r,
    output logic [3:0]          pan_shift_r,
    output logic                uline_odd_r,
    output logic                clock_select_line_three_r,
    output logic                clk_mux_freeze_r,
    output logic                crt_full_clk_r,
    output logic                char_address_bit17_r,
    output logic                char_address_bit16_r,
    output logic                scan_double_r,
    output logic                blanking_output_r,
    output logic                pixel_clock_r,
    output logic                video_oe_r,
    output logic                mem_oe_r,
    output logic                cga_video_en_eff_r,
    output logic                read_block_r,
    output logic                shift256_r
);
    import vcl_pkg::*;
    // ---------------------------------------------
    // pin synchronisers
    // ---------------------------------------------
    logic [1:0] strap_s_r;
    logic [1:0] video_clock_input_s_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strap_s_r <= 2'b00;
            video_clock_input_s_r  <= 2'b00;
        end else begin
            strap_s_r <= {strap_s_r[0], external_clock_strap};
            video_clock_input_s_r  <= {video_clock_input_s_r[0], video_clock_input};
        end
    end
    wire logic strap = strap_s_r[1];
    // ---------------------------------------------
    // host decode
    // ---------------------------------------------
    logic [7:0] gfx_idx_r;
    logic [7:0] video_select_r;
    logic [7:0] crt_lock_control_r;
    logic [7:0] video_output_control_r;
    logic [2:0] unlock_bits_r;
    logic       unlocked_r;
    wire logic wr_data = bus_req.wr && bus_req.addr == PORT_GFX_DATA;
    wire logic wr_ok   = wr_data && unlocked_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gfx_idx_r <= RST_REG;
        end else if (bus_req.wr && bus_req.addr == PORT_GFX_IDX) begin
            gfx_idx_r <= bus_req.data;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unlock_bits_r <= 3'b000;
            unlocked_r    <= 1'b0;
        end else if (wr_data && gfx_idx_r == IDX_UNLOCK) begin
            unlock_bits_r <= bus_req.data[2:0];
            unlocked_r    <= bus_req.data[3:0] == UNLOCK_KEY; // [R24]
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            video_select_r         <= RST_REG; // [R26]
            crt_lock_control_r     <= RST_REG; // [R26]
            video_output_control_r <= RST_REG; // [R26]
        end else if (wr_ok) begin // [R24]
            if (gfx_idx_r == IDX_VIDEO_SELECT) begin
                video_select_r <= bus_req.data;
            end
            if (gfx_idx_r == IDX_CRT_LOCK) begin
                crt_lock_control_r <= bus_req.data;
            end
            if (gfx_idx_r == IDX_VIDEO_OUT) begin
                video_output_control_r <= bus_req.data;
            end
        end
    end
    // ---------------------------------------------
    // register reads
    // ---------------------------------------------
    logic [7:0] rd_val;
    logic       rd_hit;
    always_comb begin
        rd_val = RST_REG;
        rd_hit = 1'b1;
        case (gfx_idx_r)
            IDX_VIDEO_SELECT: rd_val = video_select_r;
            IDX_CRT_LOCK:     rd_val = crt_lock_control_r;
            IDX_VIDEO_OUT:    rd_val = video_output_control_r;
            IDX_UNLOCK:       rd_val = {5'b00000, unlock_bits_r};
            default:          rd_hit = 1'b0;
        endcase
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_ack_r  <= 1'b0;
            rd_data_r <= RST_REG;
        end else begin
            rd_ack_r  <= bus_req.rd && bus_req.addr == PORT_GFX_DATA && rd_hit
                         && !video_output_control_r[VO_EGA]; // [R22]
            rd_data_r <= rd_val;
        end
    end
    // ---------------------------------------------
    // crt and misc write masking
    // ---------------------------------------------
    wire logic hlock = crt_lock_control_r[CL_HLOCK];
    wire logic vlock = crt_lock_control_r[CL_VLOCK];
    logic [7:0] lock_m;
    always_comb begin
        lock_m = RST_REG;
        if (crt_index <= CRT_R05 && (hlock || crt_protect)) begin
            lock_m = M_ALL; // [R9]
        end
        if (crt_index == CRT_R07) begin
            if (!crt_lock_control_r[CL_PREV] && crt_protect) begin
                lock_m = lock_m | M07_GRP1; // [R10]
            end
            if (vlock || crt_protect) begin
                lock_m = lock_m | M07_GRP2; // [R11]
            end
        end
        if (crt_index == CRT_R06 && (vlock || crt_protect)) begin
            lock_m = M_ALL; // [R11]
        end
        if (vlock) begin
            case (crt_index)
                CRT_R09: lock_m = M09_GRP3; // [R12]
                CRT_R10: lock_m = M_ALL;    // [R12]
                CRT_R11: lock_m = M11_GRP3; // [R12]
                CRT_R15: lock_m = M_ALL;    // [R12]
                CRT_R16: lock_m = M_ALL;    // [R12]
                default: lock_m = lock_m;
            endcase
        end
        if (crt_index == CRT_R17 && hlock) begin
            lock_m = M17_GRP4; // [R13]
        end
    end
    wire logic crt_wr = bus_req.wr
        && (bus_req.addr == PORT_CRT_MONO || bus_req.addr == PORT_CRT_COLR);
    wire logic misc_wr = bus_req.wr && bus_req.addr == PORT_MISC_WR;
    wire logic [7:0] pol_m = {crt_lock_control_r[CL_VPOL],
                              crt_lock_control_r[CL_HPOL], 6'b000000};
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fwd_wr_r <= '0;
        end else begin
            fwd_wr_r.pass <= crt_wr || misc_wr;
            fwd_wr_r.data <= bus_req.data;
            if (crt_wr) begin
                fwd_wr_r.mask <= ~lock_m; // [R25]
            end else if (misc_wr) begin
                fwd_wr_r.mask <= ~(pol_m & M_MISC_POL); // [R14]
            end else begin
                fwd_wr_r.mask <= M_ALL;
            end
        end
    end
    // ---------------------------------------------
    // text, clock and output controls
    // ---------------------------------------------
    wire logic [1:0] cclk = video_select_r[VS_CCLK +: 2];
    wire logic ten_dot = cclk == 2'b11 && !graphics_mode;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cell_width_r <= CW_STD;
            pan_shift_r  <= 4'h0;
        end else begin
            if (graphics_mode) begin
                cell_width_r <= CW_STD; // [R4]
            end else begin
                case (cclk) // [R3]
                    2'b01:   cell_width_r <= CW_7;
                    2'b10:   cell_width_r <= CW_9;
                    2'b11:   cell_width_r <= CW_10;
                    default: cell_width_r <= CW_STD;
                endcase
            end
            if (!ten_dot) begin
                pan_shift_r <= pan_value;
            end else if (pan_value == PAN_ZERO) begin
                pan_shift_r <= 4'h0; // [R5]
            end else if (pan_value == PAN_ONE) begin
                pan_shift_r <= 4'h1; // [R5]
            end else begin
                pan_shift_r <= 4'(pan_value + 4'h2); // [R5]
            end
        end
    end
    wire logic map_sel = video_select_r[VS_MAP];
    wire logic uline   = video_select_r[VS_ULINE];
    wire logic clk3    = video_select_r[VS_CLK3];
    wire logic [7:0] vo = video_output_control_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            legacy_timing_r           <= 1'b0;
            glyph_plane3_r            <= 1'b0;
            uline_odd_r               <= 1'b0;
            clock_select_line_three_r <= 1'b0;
            clk_mux_freeze_r          <= 1'b0;
            crt_full_clk_r            <= 1'b0;
            char_address_bit17_r      <= 1'b0;
            char_address_bit16_r      <= 1'b0;
            scan_double_r             <= 1'b0;
        end else begin
            legacy_timing_r <= video_select_r[VS_LEGACY]; // [R1]
            glyph_plane3_r  <= !page_mode_addressing && map_sel
                               && (!uline || attribute_bit_four); // [R2]
            uline_odd_r     <= uline; // [R6]
            clock_select_line_three_r <= strap && clk3;  // [R7]
            clk_mux_freeze_r          <= !strap && clk3; // [R7]
            crt_full_clk_r  <= video_select_r[VS_FORCE]
                               || !sequencer_clocking_mode; // [R8]
            char_address_bit17_r <= crt_lock_control_r[CL_B9]; // [R15]
            char_address_bit16_r <= crt_lock_control_r[CL_B8]; // [R15]
            scan_double_r   <= crt_lock_control_r[CL_DBL]; // [R16]
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            blanking_output_r  <= 1'b0;
            pixel_clock_r      <= 1'b0;
            video_oe_r         <= 1'b1;
            mem_oe_r           <= 1'b1;
            cga_video_en_eff_r <= 1'b0;
            read_block_r       <= 1'b0;
            shift256_r         <= 1'b0;
        end else begin
            if (!vo[VO_BLANKING_OUTPUT]) begin
                blanking_output_r <= blank_in; // [R17]
            end else if (enable_timing_variant) begin
                blanking_output_r <= disp_en_b; // [R17]
            end else begin
                blanking_output_r <= disp_en_a; // [R17]
            end
            pixel_clock_r <= vo[VO_PCLK] ? video_clock_input_s_r[1] : dot_clock_level; // [R18]
            video_oe_r    <= !vo[VO_VTRI]; // [R19]
            mem_oe_r      <= !vo[VO_MTRI]; // [R20]
            cga_video_en_eff_r <= cga_video_en
                                  || (vo[VO_CGA] && legacy_80x25); // [R21]
            read_block_r  <= vo[VO_EGA]; // [R22]
            shift256_r    <= vo[VO_SHIFT]; // [R23]
        end
    end
    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_LOCKED_WR: assert property ( // [R24]
        wr_data && !unlocked_r |=> $stable(video_select_r)
            && $stable(crt_lock_control_r) && $stable(video_output_control_r))
        else $error("register changed while locked");
    AST_UNLOCK: assert property ( // [R24]
        wr_data && gfx_idx_r == IDX_UNLOCK |=> unlocked_r
            == ($past(bus_req.data[3:0]) == UNLOCK_KEY))
        else $error("unlock flag wrong");
    AST_HGRP: assert property ( // [R9]
        crt_wr && crt_index == 8'h02 && (hlock || crt_protect)
            |=> fwd_wr_r.pass && fwd_wr_r.mask == 8'h00)
        else $error("horizontal group not locked");
    AST_GRP1: assert property ( // [R10]
        crt_wr && crt_index == CRT_R07 && crt_lock_control_r[CL_PREV]
            && !vlock |=> fwd_wr_r.mask[6] && fwd_wr_r.mask[1])
        else $error("group one locked despite prevention");
    AST_GRP3: assert property ( // [R12]
        crt_wr && crt_index == CRT_R10 |=> fwd_wr_r.mask == ($past(vlock) ? 8'h00 : 8'hFF))
        else $error("group three lock wrong");
    AST_POL: assert property ( // [R14]
        misc_wr |=> fwd_wr_r.mask[7] == !$past(crt_lock_control_r[CL_VPOL]))
        else $error("polarity lock wrong");
    AST_PLANE: assert property ( // [R2]
        page_mode_addressing |=> !glyph_plane3_r)
        else $error("plane select not overridden");
    AST_CW: assert property ( // [R4]
        graphics_mode |=> cell_width_r == CW_STD)
        else $error("cell width in graphics");
    AST_PAN: assert property ( // [R5]
        ten_dot && pan_value == 4'h7 |=> pan_shift_r == 4'h9)
        else $error("pan remap wrong");
    AST_READ: assert property ( // [R22]
        video_output_control_r[VO_EGA] && $stable(video_output_control_r)
            |=> !rd_ack_r)
        else $error("read not blocked");
    AST_TRI: assert property ( // [R19]
        ##1 $past(vo[VO_VTRI]) |-> !video_oe_r)
        else $error("video not floated");
    COV_UNLOCK_WR: cover property (wr_ok && gfx_idx_r == IDX_CRT_LOCK);
    COV_CRT_LOCKED: cover property (crt_wr && lock_m != 8'h00);
    COV_TEN_DOT: cover property (ten_dot && pan_value == PAN_ONE);
endmodule
`default_nettype wire

// ===== dv/video_ctrl_crtc_lock_regs_bench.sv
// self-checking bench for the video control lock registers
`timescale 1ns/1ps
`default_nettype none
module video_ctrl_crtc_lock_regs_bench;
    import vcl_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    vcl_req_t   bus_req = '0;
    logic [7:0] crt_index = 8'h00;
    logic       crt_protect = 1'b0;
    logic       gfx = 1'b0;
    logic       attr4 = 1'b0;
    logic       seq_half = 1'b0;
    logic [3:0] pan = 4'h0;
    logic       strap = 1'b0, dot = 1'b0, page = 1'b0, blank = 1'b0;
    logic       den_b = 1'b0, den_var = 1'b0, l80 = 1'b0;
    logic       clk3_out, mux_frz, blank_out, pclk, cga_eff, rd_blk;
    logic       rd_ack;
    logic [7:0] rd_data;
    vcl_wr_t    fwd;
    vcl_cw_t    cw;
    logic [3:0] pan_sh;
    logic       legacy, plane3, uline, full_clk, ca17, ca16, dbl, video_oe, mem_oe, sh256;
    int         err_total = 0;
    int         checked = 0;
    int         cyc = 0;

    vcl_regs dut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rd_ack_r(rd_ack),
        .rd_data_r(rd_data), .crt_index(crt_index), .crt_protect(crt_protect),
        .fwd_wr_r(fwd), .external_clock_strap(strap), .video_clock_input(1'b0),
        .dot_clock_level(dot), .graphics_mode(gfx), .page_mode_addressing(page),
        .attribute_bit_four(attr4), .sequencer_clocking_mode(seq_half),
        .pan_value(pan), .blank_in(blank), .disp_en_a(1'b0), .disp_en_b(den_b),
        .enable_timing_variant(den_var), .legacy_80x25(l80), .cga_video_en(1'b0),
        .legacy_timing_r(legacy), .glyph_plane3_r(plane3), .cell_width_r(cw),
        .pan_shift_r(pan_sh), .uline_odd_r(uline), .clock_select_line_three_r(clk3_out),
        .clk_mux_freeze_r(mux_frz), .crt_full_clk_r(full_clk), .char_address_bit17_r(ca17),
        .char_address_bit16_r(ca16), .scan_double_r(dbl), .blanking_output_r(blank_out),
        .pixel_clock_r(pclk), .video_oe_r(video_oe), .mem_oe_r(mem_oe),
        .cga_video_en_eff_r(cga_eff), .read_block_r(rd_blk), .shift256_r(sh256));

    always #2 clk_sys = ~clk_sys;

    // ---------------------------------------------
    // shared tasks
    // ---------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus_req = '{wr: w, rd: ~w, addr: a, data: d};
        @(negedge clk_sys);
        bus_req.wr = 1'b0;
        bus_req.rd = 1'b0;
    endtask

    task automatic wr_ext(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, PORT_GFX_IDX, idx);
        bus(1'b1, PORT_GFX_DATA, d);
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic rd_ext(input logic [7:0] idx, output logic ack, output logic [7:0] d);
        ack = 1'b0;
        d = 8'hxx;
        bus(1'b1, PORT_GFX_IDX, idx);
        bus(1'b0, PORT_GFX_DATA, 8'h00);
        repeat (3) begin
            if (rd_ack === 1'b1 && !ack) begin
                ack = 1'b1;
                d = rd_data;
            end
            @(negedge clk_sys);
        end
    endtask

    task automatic wr_crt(input logic [15:0] port, input logic [7:0] idx, output logic [7:0] m);
        m = 8'hxx;
        @(negedge clk_sys);
        crt_index = idx;
        bus(1'b1, port, 8'h5A);
        repeat (3) begin
            if (fwd.pass === 1'b1) begin
                m = fwd.mask;
            end
            @(negedge clk_sys);
        end
    endtask

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_reset();
        logic ack;
        logic [7:0] d;
        for (int i = 0; i < 3; i++) begin
            rd_ext(IDX_VIDEO_SELECT + 8'(i), ack, d);
            chk("reset ack", 8'h01, {7'h00, ack});
            chk("reset value", 8'h00, d);
        end
        chk("video drive", 8'h01, {7'h00, video_oe});
        chk("memory drive", 8'h01, {7'h00, mem_oe});
        $display("test reset done");
    endtask

    task automatic t_unlock();
        logic ack;
        logic [7:0] d;
        wr_ext(IDX_VIDEO_SELECT, 8'h20);
        rd_ext(IDX_VIDEO_SELECT, ack, d);
        chk("locked write", 8'h00, d);
        wr_ext(IDX_UNLOCK, 8'hA5);
        wr_ext(IDX_VIDEO_SELECT, 8'h20);
        rd_ext(IDX_VIDEO_SELECT, ack, d);
        chk("unlocked write", 8'h20, d);
        wr_ext(IDX_UNLOCK, 8'h04);
        wr_ext(IDX_VIDEO_SELECT, 8'h00);
        rd_ext(IDX_VIDEO_SELECT, ack, d);
        chk("relocked write", 8'h20, d);
        wr_ext(IDX_UNLOCK, 8'h05);
        $display("test unlock done");
    endtask

    task automatic t_text();
        for (int c = 0; c < 4; c++) begin
            wr_ext(IDX_VIDEO_SELECT, 8'(c << 3));
            chk("cell width", 8'(1 << c), {4'h0, cw});
        end
        gfx = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("graphics width", {4'h0, CW_STD}, {4'h0, cw});
        gfx = 1'b0;
        for (int p = 0; p < 10; p++) begin
            pan = 4'(p);
            repeat (3) @(negedge clk_sys);
            chk("pan shift", (p == 9) ? 8'h00 : (p == 8) ? 8'h01 : 8'(p + 2), {4'h0, pan_sh});
        end
        for (int k = 0; k < 8; k++) begin
            attr4 = k[0];
            wr_ext(IDX_VIDEO_SELECT, {2'b00, k[2], 2'b00, k[1], 2'b00});
            chk("glyph plane", {7'h00, k[2] & (~k[1] | k[0])}, {7'h00, plane3});
        end
        $display("test text done");
    endtask

    task automatic t_levels();
        seq_half = 1'b1;
        wr_ext(IDX_VIDEO_SELECT, 8'h45);
        chk("legacy timing", 8'h01, {7'h00, legacy});
        chk("odd underline", 8'h01, {7'h00, uline});
        chk("full clock", 8'h01, {7'h00, full_clk});
        wr_ext(IDX_CRT_LOCK, 8'h1C);
        chk("address ext", 8'h03, {6'h00, ca17, ca16});
        chk("scan double", 8'h01, {7'h00, dbl});
        wr_ext(IDX_VIDEO_OUT, 8'h31);
        chk("video float", 8'h00, {7'h00, video_oe});
        chk("memory float", 8'h00, {7'h00, mem_oe});
        chk("shift 256", 8'h01, {7'h00, sh256});
        wr_ext(IDX_VIDEO_OUT, 8'h00);
        $display("test levels done");
    endtask

    task automatic t_pins();
        wr_ext(IDX_VIDEO_SELECT, 8'h22);
        chk("free clock", 8'h02, {6'h00, mux_frz, clk3_out});
        strap = 1'b1;
        page = 1'b1;
        blank = 1'b1;
        den_b = 1'b1;
        dot = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("strap clock", 8'h01, {6'h00, mux_frz, clk3_out});
        chk("page plane", 8'h00, {7'h00, plane3});
        chk("blank pass", 8'h01, {7'h00, blank_out});
        chk("dot clock", 8'h01, {7'h00, pclk});
        wr_ext(IDX_VIDEO_OUT, 8'hC0);
        chk("enable a", 8'h00, {7'h00, blank_out});
        chk("video clock", 8'h00, {7'h00, pclk});
        den_var = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("enable b", 8'h01, {7'h00, blank_out});
        wr_ext(IDX_VIDEO_OUT, 8'h08);
        chk("cga other mode", 8'h00, {7'h00, cga_eff});
        l80 = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("cga override", 8'h01, {7'h00, cga_eff});
        wr_ext(IDX_VIDEO_OUT, 8'h00);
        $display("test pins done");
    endtask

    task automatic t_locks();
        logic [31:0] tb [12] = '{32'h20_00_00_00, 32'h00_01_05_00, 32'h00_00_05_FF,
            32'h00_01_07_10, 32'h02_01_07_52, 32'h01_00_07_52, 32'h01_00_06_00,
            32'h01_00_10_00, 32'h00_01_10_FF, 32'h01_00_09_DF, 32'h01_00_11_F0,
            32'h20_00_17_FB};
        logic [7:0] m;
        for (int i = 0; i < 12; i++) begin
            crt_protect = tb[i][16];
            wr_ext(IDX_CRT_LOCK, tb[i][31:24]);
            wr_crt(PORT_CRT_COLR, tb[i][15:8], m);
            chk("crt mask", tb[i][7:0], m);
        end
        crt_protect = 1'b0;
        wr_ext(IDX_CRT_LOCK, 8'hC0);
        wr_crt(PORT_MISC_WR, 8'h00, m);
        chk("polarity mask", 8'h3F, m);
        wr_ext(IDX_CRT_LOCK, 8'h20);
        wr_crt(PORT_CRT_MONO, 8'h02, m);
        chk("mono mask", 8'h00, m);
        $display("test locks done");
    endtask

    task automatic t_readblock();
        logic ack;
        logic [7:0] d;
        wr_ext(IDX_VIDEO_OUT, 8'h02);
        chk("read block flag", 8'h01, {7'h00, rd_blk});
        rd_ext(IDX_CRT_LOCK, ack, d);
        chk("blocked read", 8'h00, {7'h00, ack});
        wr_ext(IDX_VIDEO_OUT, 8'h00);
        rd_ext(IDX_CRT_LOCK, ack, d);
        chk("open read", 8'h01, {7'h00, ack});
        $display("test readblock done");
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_unlock();
        t_text();
        t_levels();
        t_pins();
        t_locks();
        t_readblock();
        report_and_stop();
    end
endmodule
`default_nettype wire
